// ===== fcr_defines.vh
// constants for the flash configuration register block
`ifndef FCR_DEFINES_VH
`define FCR_DEFINES_VH
// serial command codes
`define FCR_CMD_RD_STATUS    8'h05
`define FCR_CMD_RD_BOOT      8'hB5
`define FCR_CMD_WR_BOOT      8'hB1
`define FCR_CMD_RD_LIVE      8'h85
`define FCR_CMD_WR_LIVE      8'h81
// frame lengths in serial bits, command byte included, then last command bit index and bit counter limit
`define FCR_WR_BOOT_BITS     5'h18
`define FCR_WR_LIVE_BITS     5'h10
`define FCR_CMD_LAST_BIT     5'h07
`define FCR_BITS_MAX         5'h1F
// reset values
`define FCR_BOOT_RESET       16'hFFFF
`define FCR_LIVE_RESET       8'hFB
// boot_configuration field positions
`define FCR_BOOT_DUMMY_HI    15
`define FCR_BOOT_DUMMY_LO    12
`define FCR_BOOT_DCF_HI      11
`define FCR_BOOT_DCF_LO      9
`define FCR_BOOT_DRV_HI      8
`define FCR_BOOT_DRV_LO      6
`define FCR_BOOT_HOLD        4
`define FCR_BOOT_QUAD        3
`define FCR_BOOT_DUAL        2
`define FCR_BOOT_LOCK        0
// live_configuration field positions
`define FCR_LIVE_DUMMY_HI    7
`define FCR_LIVE_DUMMY_LO    4
`define FCR_LIVE_DCF_OFF     3
`define FCR_LIVE_FIXED0      2
`define FCR_LIVE_WRAP_HI     1
`define FCR_LIVE_WRAP_LO     0
// field codes
`define FCR_DUMMY_ZERO       4'h0
`define FCR_DUMMY_ONES       4'hF
`define FCR_DUMMY_DEFAULT    4'hA
`define FCR_DCF_DISABLED     3'h7
`define FCR_DCF_FAST         3'h0
`define FCR_DCF_LAST_VALID   3'h4
`define FCR_DRV_RSVD_A       3'h0
`define FCR_DRV_RSVD_B       3'h4
`define FCR_DRV_DEFAULT      3'h7
`define FCR_WRAP_16          2'h0
`define FCR_WRAP_32          2'h1
`define FCR_WRAP_64          2'h2
`define FCR_WRAP_SEQ         2'h3
// timing
`define FCR_CLK_MHZ          25
`define FCR_NV_WRITE_US      200
`endif

// ===== fcr_config_regs.v
// configuration register block of a serial flash, serial slave plus working configuration
`timescale 1ns/1ps
`include "fcr_defines.vh"

module fcr_config_regs #(
  parameter NV_WRITE_CYCLES = `FCR_NV_WRITE_US * `FCR_CLK_MHZ,
  parameter DCF_BIT_IGNORED = 0
) (
  input  wire        CLK,
  input  wire        RESET_N,
  input  wire        SPI_SCK,
  input  wire        SPI_CS_N,
  input  wire        SPI_SI,
  output wire        SPI_SO,
  output wire        SPI_SO_OE,
  output reg  [3:0]  DUMMY_CYCLES,
  output reg         DIRECT_CODE_FETCH_MODE,
  output reg  [2:0]  DCF_READ_TYPE,
  output reg  [2:0]  DRIVE_STRENGTH,
  output reg         HOLD_RESET_EN,
  output reg         PROTOCOL_QUAD,
  output reg         PROTOCOL_DUAL,
  output reg         WRITE_BUSY,
  output reg  [3:0]  WRAP_MODE,
  input  wire        ADDR_LOAD,
  input  wire [23:0] ADDR_IN,
  input  wire        ADDR_STEP,
  output reg  [23:0] READ_ADDR
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_CMD  = 5'h02;
  localparam [4:0] ST_DIN  = 5'h04;
  localparam [4:0] ST_DOUT = 5'h08;
  localparam [4:0] ST_SKIP = 5'h10;

  // cut on purpose: the busy counter is 16 bits, so only the low 16 bits of the write time are kept
  localparam [31:0] NV_WRITE_LAST_W = NV_WRITE_CYCLES - 1;
  localparam [15:0] NV_WRITE_LAST   = NV_WRITE_LAST_W[15:0];

  // pin synchronisers
  reg         sck_s1_reg;
  reg         sck_s2_reg;
  reg         sck_d_reg;
  reg         cs_s1_reg;
  reg         cs_s2_reg;
  reg         cs_d_reg;
  reg         si_s1_reg;
  reg         si_s2_reg;

  reg  [4:0]  state_reg;
  reg  [4:0]  state_next;
  reg  [4:0]  bits_reg;
  reg  [23:0] shift_reg;
  reg  [7:0]  cmd_reg;
  reg  [15:0] out_reg;

  reg  [15:0] boot_configuration_reg;
  reg  [7:0]  live_configuration_reg;
  reg  [15:0] boot_pending_reg;
  reg  [15:0] busy_cnt_reg;
  reg         boot_load_reg;

  wire        sck_rise = sck_s2_reg & ~sck_d_reg;
  wire        sck_fall = ~sck_s2_reg & sck_d_reg;
  wire        cs_start = ~cs_s2_reg & cs_d_reg;
  wire        cs_end   = cs_s2_reg & ~cs_d_reg;
  wire [7:0]  cmd_now  = {shift_reg[6:0], si_s2_reg};
  wire        cmd_done = sck_rise & (bits_reg == `FCR_CMD_LAST_BIT);
  wire [3:0]  live_dummy = live_configuration_reg[`FCR_LIVE_DUMMY_HI:`FCR_LIVE_DUMMY_LO];
  wire [1:0]  live_wrap  = live_configuration_reg[`FCR_LIVE_WRAP_HI:`FCR_LIVE_WRAP_LO];
  wire [2:0]  boot_dcf   = boot_configuration_reg[`FCR_BOOT_DCF_HI:`FCR_BOOT_DCF_LO];
  wire [2:0]  boot_drv   = boot_configuration_reg[`FCR_BOOT_DRV_HI:`FCR_BOOT_DRV_LO];
  wire        boot_locked = ~boot_configuration_reg[`FCR_BOOT_LOCK];

  assign SPI_SO    = out_reg[15];
  assign SPI_SO_OE = (state_reg == ST_DOUT) & ~cs_s2_reg;

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_d_reg  <= 1'b0;
      cs_s1_reg  <= 1'b1;
      cs_s2_reg  <= 1'b1;
      cs_d_reg   <= 1'b1;
      si_s1_reg  <= 1'b0;
      si_s2_reg  <= 1'b0;
    end else begin
      sck_s1_reg <= SPI_SCK;
      sck_s2_reg <= sck_s1_reg;
      sck_d_reg  <= sck_s2_reg;
      cs_s1_reg  <= SPI_CS_N;
      cs_s2_reg  <= cs_s1_reg;
      cs_d_reg   <= cs_s2_reg;
      si_s1_reg  <= SPI_SI;
      si_s2_reg  <= si_s1_reg;
    end
  end

  // frame sequencer
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cs_start) begin
          state_next = ST_CMD;
        end
      end
      ST_CMD: begin
        if (cs_end) begin
          state_next = ST_IDLE;
        end else if (cmd_done) begin
          case (cmd_now)
            `FCR_CMD_RD_BOOT, `FCR_CMD_RD_LIVE, `FCR_CMD_RD_STATUS: state_next = ST_DOUT;
            `FCR_CMD_WR_BOOT, `FCR_CMD_WR_LIVE: state_next = ST_DIN;
            default: state_next = ST_SKIP;
          endcase
        end
      end
      ST_DIN, ST_DOUT, ST_SKIP: begin
        if (cs_end) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= ST_IDLE;
      bits_reg  <= 5'h00;
      shift_reg <= 24'h000000;
      cmd_reg   <= 8'h00;
      out_reg   <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (cs_start) begin
        bits_reg <= 5'h00;
      end else if (sck_rise & ~cs_s2_reg) begin
        shift_reg <= {shift_reg[22:0], si_s2_reg};
        if (bits_reg != `FCR_BITS_MAX) begin
          bits_reg <= bits_reg + 5'h01;
        end
      end
      if ((state_reg == ST_CMD) & cmd_done) begin
        cmd_reg <= cmd_now;
        // loaded rotated right so the first falling edge shows the top bit
        // boot stream is low byte then high byte, each most significant bit first
        case (cmd_now)
          `FCR_CMD_RD_BOOT:
            out_reg <= {boot_configuration_reg[8], boot_configuration_reg[7:0],
                        boot_configuration_reg[15:9]};
          `FCR_CMD_RD_LIVE:
            out_reg <= {live_configuration_reg[0], live_configuration_reg,
                        live_configuration_reg[7:1]};
          // busy flag in status bit 0
          `FCR_CMD_RD_STATUS:
            out_reg <= {WRITE_BUSY, 7'h00, WRITE_BUSY, 7'h00};
          default: out_reg <= out_reg;
        endcase
      end else if ((state_reg == ST_DOUT) & sck_fall) begin
        out_reg <= {out_reg[14:0], out_reg[15]};
      end
    end
  end

  // configuration store and boot load
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      boot_configuration_reg <= `FCR_BOOT_RESET;
      live_configuration_reg <= `FCR_LIVE_RESET;
      boot_pending_reg       <= `FCR_BOOT_RESET;
      busy_cnt_reg           <= 16'h0000;
      WRITE_BUSY             <= 1'b0;
      boot_load_reg          <= 1'b1;
      // disabled from reset, so fetch mode shows no pulse before the boot load
      DCF_READ_TYPE          <= `FCR_DCF_DISABLED;
      DRIVE_STRENGTH         <= `FCR_DRV_DEFAULT;
      HOLD_RESET_EN          <= 1'b1;
      PROTOCOL_QUAD          <= 1'b0;
      PROTOCOL_DUAL          <= 1'b0;
    end else begin
      boot_load_reg <= 1'b0;
      if (boot_load_reg) begin
        // working configuration taken from the boot register
        // live dummy field seeded from boot field
        live_configuration_reg[`FCR_LIVE_DUMMY_HI:`FCR_LIVE_DUMMY_LO] <=
          boot_configuration_reg[`FCR_BOOT_DUMMY_HI:`FCR_BOOT_DUMMY_LO];
        DCF_READ_TYPE <= boot_dcf;
        // reserved drive codes fall back to the default strength
        if ((boot_drv == `FCR_DRV_RSVD_A) | (boot_drv == `FCR_DRV_RSVD_B)) begin
          DRIVE_STRENGTH <= `FCR_DRV_DEFAULT;
        end else begin
          DRIVE_STRENGTH <= boot_drv;
        end
        HOLD_RESET_EN <= boot_configuration_reg[`FCR_BOOT_HOLD];
        // protocol latched only here, quad wins when both low
        PROTOCOL_QUAD <= ~boot_configuration_reg[`FCR_BOOT_QUAD];
        PROTOCOL_DUAL <= ~boot_configuration_reg[`FCR_BOOT_DUAL] &
                         boot_configuration_reg[`FCR_BOOT_QUAD];
      end else if (cs_end & (state_reg == ST_DIN) & (cmd_reg == `FCR_CMD_WR_LIVE) &
                   (bits_reg == `FCR_WR_LIVE_BITS)) begin
        // live write acts at once, bit 2 held at zero
        live_configuration_reg <= {shift_reg[7:3], 1'b0, shift_reg[1:0]};
      end
      // locked register ignores writes; a running write also refuses a new one
      if (cs_end & (state_reg == ST_DIN) & (cmd_reg == `FCR_CMD_WR_BOOT) &
          (bits_reg == `FCR_WR_BOOT_BITS) & ~boot_locked & ~WRITE_BUSY & ~boot_load_reg) begin
        // low byte arrives first
        boot_pending_reg <= {shift_reg[7:0], shift_reg[15:8]};
        busy_cnt_reg     <= NV_WRITE_LAST;
        // busy from the end of the frame
        WRITE_BUSY       <= 1'b1;
      end else if (WRITE_BUSY) begin
        if (busy_cnt_reg == 16'h0000) begin
          WRITE_BUSY             <= 1'b0;
          boot_configuration_reg <= boot_pending_reg;
        end else begin
          busy_cnt_reg <= busy_cnt_reg - 16'h0001;
        end
      end
    end
  end

  // working outputs that follow the live register every cycle
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DUMMY_CYCLES           <= `FCR_DUMMY_DEFAULT;
      DIRECT_CODE_FETCH_MODE <= 1'b0;
      WRAP_MODE              <= 4'h0;
    end else begin
      // both end codes mean the default count
      if ((live_dummy == `FCR_DUMMY_ZERO) | (live_dummy == `FCR_DUMMY_ONES)) begin
        DUMMY_CYCLES <= `FCR_DUMMY_DEFAULT;
      end else begin
        DUMMY_CYCLES <= live_dummy;
      end
      // live enable, boot selection, or variant that ignores the bit
      DIRECT_CODE_FETCH_MODE <= ~live_configuration_reg[`FCR_LIVE_DCF_OFF] |
                                (DCF_BIT_IGNORED != 0) |
                                (DCF_READ_TYPE <= `FCR_DCF_LAST_VALID);
      // one-hot wrap indication: 16, 32, 64, sequential
      case (live_wrap)
        `FCR_WRAP_16: WRAP_MODE <= 4'h1;
        `FCR_WRAP_32: WRAP_MODE <= 4'h2;
        `FCR_WRAP_64: WRAP_MODE <= 4'h4;
        default:      WRAP_MODE <= 4'h8;
      endcase
    end
  end

  // read address stepper; sequential mode rolls over the whole array
  reg  [23:0] wrap_mask;
  wire [23:0] addr_inc = READ_ADDR + 24'h000001;

  always @* begin
    case (live_wrap)
      `FCR_WRAP_16: wrap_mask = 24'h00000F;
      `FCR_WRAP_32: wrap_mask = 24'h00001F;
      `FCR_WRAP_64: wrap_mask = 24'h00003F;
      default:      wrap_mask = 24'hFFFFFF;
    endcase
  end

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      READ_ADDR <= 24'h000000;
    end else if (ADDR_LOAD) begin
      READ_ADDR <= ADDR_IN;
    end else if (ADDR_STEP) begin
      READ_ADDR <= (READ_ADDR & ~wrap_mask) | (addr_inc & wrap_mask);
    end
  end

endmodule

// ===== fcr_checker.sv
// port checker for the flash configuration register block
`timescale 1ns/1ps
module fcr_checker #(
  parameter NV_WRITE_CYCLES = 20
) (
  input wire        CLK,
  input wire        RESET_N,
  input wire        SPI_CS_N,
  input wire        SPI_SO_OE,
  input wire [3:0]  DUMMY_CYCLES,
  input wire [2:0]  DRIVE_STRENGTH,
  input wire        HOLD_RESET_EN,
  input wire        PROTOCOL_QUAD,
  input wire        PROTOCOL_DUAL,
  input wire        WRITE_BUSY,
  input wire [3:0]  WRAP_MODE,
  input wire        ADDR_LOAD,
  input wire [23:0] ADDR_IN,
  input wire        ADDR_STEP,
  input wire [23:0] READ_ADDR
);
  int         busy_cnt;
  wire [23:0] step16 = {READ_ADDR[23:4], READ_ADDR[3:4'h0] + 4'h1};
  // busy cycles of the current boot write
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) busy_cnt <= 0;
    else busy_cnt <= WRITE_BUSY ? busy_cnt + 1 : 0;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_dummy_coded: assert property (DUMMY_CYCLES != 4'h0 && DUMMY_CYCLES != 4'hF)
    else $error("raw default dummy code seen");
  a_wrap_onehot: assert property ($onehot0(WRAP_MODE))
    else $error("wrap mode not one-hot");
  a_addr_load: assert property (ADDR_LOAD |=> READ_ADDR == $past(ADDR_IN))
    else $error("start address not loaded");
  a_wrap_sixteen: assert property (
    ADDR_STEP && !ADDR_LOAD && WRAP_MODE == 4'h1 |=> READ_ADDR == $past(step16))
    else $error("16-byte wrap step wrong");
  a_seq_step: assert property (
    ADDR_STEP && !ADDR_LOAD && WRAP_MODE == 4'h8 |=> READ_ADDR == $past(READ_ADDR) + 24'h1)
    else $error("sequential step wrong");
  a_busy_length: assert property ($fell(WRITE_BUSY) |-> busy_cnt == NV_WRITE_CYCLES)
    else $error("boot write busy length wrong");
  a_busy_bound: assert property (busy_cnt <= NV_WRITE_CYCLES)
    else $error("boot write busy too long");
  a_busy_after_frame: assert property ($rose(WRITE_BUSY) |-> SPI_CS_N)
    else $error("busy rose inside a frame");
  a_so_in_frame: assert property ($rose(SPI_SO_OE) |-> !SPI_CS_N)
    else $error("output driven outside a frame");
  a_boot_static: assert property (
    $stable({PROTOCOL_QUAD, PROTOCOL_DUAL, DRIVE_STRENGTH, HOLD_RESET_EN}))
    else $error("boot fields changed without power-on");
  c_busy_done: cover property ($fell(WRITE_BUSY));
  c_wrap_step: cover property (ADDR_STEP && WRAP_MODE == 4'h1);
  c_read_out: cover property ($rose(SPI_SO_OE));
endmodule
bind fcr_config_regs fcr_checker #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) fcr_checker_i (
  .CLK(CLK), .RESET_N(RESET_N), .SPI_CS_N(SPI_CS_N), .SPI_SO_OE(SPI_SO_OE),
  .DUMMY_CYCLES(DUMMY_CYCLES), .DRIVE_STRENGTH(DRIVE_STRENGTH),
  .HOLD_RESET_EN(HOLD_RESET_EN), .PROTOCOL_QUAD(PROTOCOL_QUAD),
  .PROTOCOL_DUAL(PROTOCOL_DUAL), .WRITE_BUSY(WRITE_BUSY), .WRAP_MODE(WRAP_MODE),
  .ADDR_LOAD(ADDR_LOAD), .ADDR_IN(ADDR_IN), .ADDR_STEP(ADDR_STEP), .READ_ADDR(READ_ADDR));

// ===== fcr_spi_host.sv
// serial host model issuing configuration register commands
`timescale 1ns/1ps
module fcr_spi_host (
  input  wire clk,
  output reg  sck,
  output reg  cs_n,
  output reg  si,
  input  wire so,
  input  wire so_oe
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  task xfer(input [23:0] bits, input int n, output [15:0] rd);
    rd = 16'h0000;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      sck <= 1'b0;
      si <= bits[23 - i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (3) @(posedge clk);
      // sampled late in the high phase, where the design holds its bit steady
      // the line has no pull: an undriven line reads inverted so a missing enable shows
      rd = {rd[14:0], (so_oe === 1'b1) ? so : ~so};
    end
    @(posedge clk);
    sck <= 1'b0;
    si <= ~si;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask
endmodule

// ===== tb.sv
// self-checking bench for the flash configuration register block
`timescale 1ns/1ps
`include "fcr_defines.vh"
module tb;
  localparam NV = 200;
  reg         clk, rst_n, addr_load, addr_step;
  reg  [23:0] addr_in;
  wire        sck, cs_n, si, so, so_oe, dcf_mode, hold, quad, dual, busy;
  wire [3:0]  dummy, wrap;
  wire [2:0]  dcf_type, drv;
  wire [23:0] raddr;
  int         bad_count, total_checks;
  fcr_config_regs #(.NV_WRITE_CYCLES(NV)) fcr_config_regs_i (
    .CLK(clk), .RESET_N(rst_n), .SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_SI(si), .SPI_SO(so),
    .SPI_SO_OE(so_oe), .DUMMY_CYCLES(dummy), .DIRECT_CODE_FETCH_MODE(dcf_mode),
    .DCF_READ_TYPE(dcf_type), .DRIVE_STRENGTH(drv), .HOLD_RESET_EN(hold),
    .PROTOCOL_QUAD(quad), .PROTOCOL_DUAL(dual), .WRITE_BUSY(busy), .WRAP_MODE(wrap),
    .ADDR_LOAD(addr_load), .ADDR_IN(addr_in), .ADDR_STEP(addr_step), .READ_ADDR(raddr));
  fcr_spi_host fcr_spi_host_i (
    .clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] %0s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask
  task wr(input [7:0] cmd, input [15:0] v, input int n);
    logic [15:0] r;
    fcr_spi_host_i.xfer((n == 24) ? {cmd, v[7:0], v[15:8]} : {cmd, v[7:0], 8'h00}, n, r);
  endtask
  task rd_chk(input [7:0] cmd, input int n, input [15:0] exp, input string name);
    logic [15:0] r;
    fcr_spi_host_i.xfer({cmd, 16'h0000}, n, r);
    chk(name, exp, (n == 24) ? {r[7:0], r[15:8]} : {8'h00, r[7:0]});
  endtask
  task addr_op(input ld, input [23:0] a);
    @(posedge clk);
    addr_load <= ld;
    addr_step <= !ld;
    addr_in <= a;
    @(posedge clk);
    addr_load <= 1'b0;
    addr_step <= 1'b0;
    #1;
  endtask
  task wait_idle;
    for (int i = 0; i < 4 * NV && busy !== 1'b0; i++) @(posedge clk);
    #1;
  endtask
  task t_reset;
    #1;
    chk("dummy", 4'hA, dummy);
    chk("read type", 3'h7, dcf_type);
    chk("drive", 3'h7, drv);
    chk("hold", 1'b1, hold);
    chk("protocol", 2'b00, {quad, dual});
    chk("wrap", 4'h8, wrap);
    chk("fetch", 1'b0, dcf_mode);
    rd_chk(`FCR_CMD_RD_BOOT, 24, 16'hFFFF, "boot");
    rd_chk(`FCR_CMD_RD_LIVE, 16, 16'h00FB, "live");
    rd_chk(`FCR_CMD_RD_STATUS, 16, 16'h0000, "status");
  endtask
  task t_live;
    logic [3:0]  d;
    logic [23:0] a;
    for (int w = 0; w < 4; w++) begin
      d = 4'(w * 5);
      wr(`FCR_CMD_WR_LIVE, {8'h00, d, 2'b11, 2'(w)}, 16);
      chk("dummy", (d == 4'h0 || d == 4'hF) ? 4'hA : d, dummy);
      chk("wrap", 4'h1 << w, wrap);
      chk("fetch", 1'b0, dcf_mode);
      rd_chk(`FCR_CMD_RD_LIVE, 16, {8'h00, d, 2'b10, 2'(w)}, "live");
      // one step from the last byte of a block: 16, 32, 64 wrap, then sequential
      a = (w == 0) ? 24'h123470 : (w == 1) ? 24'h123460 : (w == 2) ? 24'h123440 : 24'h123480;
      addr_op(1'b1, 24'h12347F);
      addr_op(1'b0, 24'h000000);
      chk("addr", a, raddr);
    end
    wr(`FCR_CMD_WR_LIVE, 16'h0033, 16);
    chk("fetch", 1'b1, dcf_mode);
    chk("dummy", 4'h3, dummy);
  endtask
  task t_boot;
    wr(`FCR_CMD_WR_BOOT, 16'h3885, 24);
    chk("busy", 1'b1, busy);
    rd_chk(`FCR_CMD_RD_STATUS, 16, 16'h0001, "status");
    wait_idle;
    chk("busy", 1'b0, busy);
    rd_chk(`FCR_CMD_RD_STATUS, 16, 16'h0000, "status");
    chk("protocol", 2'b00, {quad, dual});
    rd_chk(`FCR_CMD_RD_BOOT, 24, 16'h3885, "boot");
    wr(`FCR_CMD_WR_BOOT, 16'h3884, 24);
    wait_idle;
    wr(`FCR_CMD_WR_BOOT, 16'h1235, 24);
    chk("busy", 1'b0, busy);
    rd_chk(`FCR_CMD_RD_BOOT, 24, 16'h3884, "boot");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    addr_load = 1'b0;
    addr_step = 1'b0;
    addr_in = 24'h000000;
    bad_count = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_live;
    t_boot;
    print_verdict;
  end
  initial begin
    #2000000;
    bad_count++;
    print_verdict;
  end
endmodule
